// ===== rtl/irq_aggr_pkg.sv
package irq_aggr_pkg;

  // line and flag geometry
  localparam int NUM_LINES   = 25;
  localparam int FLAG_W      = 8;
  localparam int CTRL_W      = 32;
  localparam int PRIO_REGS   = 8;
  localparam int PRIO_W      = 8;
  localparam int LINE_IDX_W  = 5;
  localparam int PRIO_IDX_W  = 3;

  // peripheral group sizes
  localparam int NUM_SYS     = 7;
  localparam int NUM_SERIAL  = 6;
  localparam int NUM_TIMER   = 8;
  localparam int NUM_ANALOG  = 4;

  // fixed line numbers of the system units
  localparam int LINE_POWER_MANAGER   = 0;
  localparam int LINE_SYSTEM_CONTROL  = 1;
  localparam int LINE_WATCHDOG        = 2;
  localparam int LINE_RT_COUNTER      = 3;
  localparam int LINE_EXT_IRQ_CTRL    = 4;
  localparam int LINE_NVM_CTRL        = 5;
  localparam int LINE_EVENT_SYSTEM    = 6;
  localparam int LINE_SYS_BASE        = LINE_POWER_MANAGER;

  // first line of each numbered group
  localparam int LINE_SERIAL_BASE     = 7;
  localparam int LINE_TIMER_BASE      = 13;

  // analog group lines
  localparam int LINE_ADC             = 21;
  localparam int LINE_ANALOG_CMP      = 22;
  localparam int LINE_DAC             = 23;
  localparam int LINE_TOUCH_CTRL      = 24;
  localparam int LINE_ANALOG_BASE     = LINE_ADC;

  // reset values
  localparam logic [FLAG_W-1:0] FLAG_RESET   = 8'h00;
  localparam logic [FLAG_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [CTRL_W-1:0] PEND_RESET   = 32'h0000_0000;
  localparam logic [CTRL_W-1:0] LINE_EN_RESET = 32'h0000_0000;
  localparam logic [CTRL_W-1:0] PRIO_RESET   = 32'h0000_0000;

  // software write to one peripheral's flag and enable registers
  typedef struct packed {
    logic                  wr;
    logic [LINE_IDX_W-1:0] unit;
    logic [FLAG_W-1:0]     flag_clr;
    logic [FLAG_W-1:0]     en_set;
    logic [FLAG_W-1:0]     en_clr;
  } unit_write_t;

  // software write to the nested vector controller
  typedef struct packed {
    logic [CTRL_W-1:0]     pend_set;
    logic [CTRL_W-1:0]     pend_clr;
    logic [CTRL_W-1:0]     ena_set;
    logic [CTRL_W-1:0]     ena_clr;
    logic                  prio_wr;
    logic [PRIO_IDX_W-1:0] prio_idx;
    logic [CTRL_W-1:0]     prio_data;
  } vctl_write_t;

endpackage

// ===== rtl/peripheral_irq_aggregation.sv
module peripheral_irq_aggregation (
  input  wire logic                                      core_clk,
  input  wire logic                                      rst_b,
  input  wire logic [irq_aggr_pkg::NUM_SYS-1:0][irq_aggr_pkg::FLAG_W-1:0]    sys_cond,
  input  wire logic [irq_aggr_pkg::NUM_SERIAL-1:0][irq_aggr_pkg::FLAG_W-1:0] serial_cond,
  input  wire logic [irq_aggr_pkg::NUM_TIMER-1:0][irq_aggr_pkg::FLAG_W-1:0]  timer_cond,
  input  wire logic [irq_aggr_pkg::NUM_ANALOG-1:0][irq_aggr_pkg::FLAG_W-1:0] analog_cond,
  input  wire logic                                      ext_nmi_cond,
  input  wire irq_aggr_pkg::unit_write_t                 unit_wr,
  input  wire irq_aggr_pkg::vctl_write_t                 vctl_wr,
  output logic [irq_aggr_pkg::NUM_LINES-1:0][irq_aggr_pkg::FLAG_W-1:0] flag_q,
  output logic [irq_aggr_pkg::NUM_LINES-1:0][irq_aggr_pkg::FLAG_W-1:0] enable_q,
  output logic [irq_aggr_pkg::NUM_LINES-1:0]             unit_req,
  output logic [irq_aggr_pkg::CTRL_W-1:0]                pending_q,
  output logic [irq_aggr_pkg::CTRL_W-1:0]                line_enable_q,
  output logic [irq_aggr_pkg::PRIO_REGS-1:0][irq_aggr_pkg::CTRL_W-1:0] priority_q,
  output logic                                           nmi_req,
  output logic                                           active_valid_q,
  output logic [irq_aggr_pkg::LINE_IDX_W-1:0]            active_line_q
);

  localparam int NL = irq_aggr_pkg::NUM_LINES;
  localparam int FW = irq_aggr_pkg::FLAG_W;
  localparam int CW = irq_aggr_pkg::CTRL_W;
  localparam int PW = irq_aggr_pkg::PRIO_W;

  logic [NL-1:0][FW-1:0] cond;
  logic [NL-1:0][FW-1:0] flag_d;
  logic [NL-1:0][FW-1:0] enable_d;
  logic [CW-1:0]         pending_d;
  logic [CW-1:0]         line_enable_d;
  logic [irq_aggr_pkg::PRIO_REGS-1:0][CW-1:0] priority_d;
  logic [CW-1:0]         req_wide;
  logic [CW-1:0]         candidate;
  logic                  active_valid_d;
  logic [irq_aggr_pkg::LINE_IDX_W-1:0] active_line_d;
  logic [PW-1:0]         best_prio;
  logic [CW*PW-1:0]      prio_flat;

  // fixed routing of each peripheral group onto its lines
  always_comb begin
    cond = '0;
    for (int i = 0; i < irq_aggr_pkg::NUM_SYS; i++) begin
      cond[irq_aggr_pkg::LINE_SYS_BASE + i] = sys_cond[i];
    end
    for (int i = 0; i < irq_aggr_pkg::NUM_SERIAL; i++) begin
      cond[irq_aggr_pkg::LINE_SERIAL_BASE + i] = serial_cond[i];
    end
    for (int i = 0; i < irq_aggr_pkg::NUM_TIMER; i++) begin
      cond[irq_aggr_pkg::LINE_TIMER_BASE + i] = timer_cond[i];
    end
    for (int i = 0; i < irq_aggr_pkg::NUM_ANALOG; i++) begin
      cond[irq_aggr_pkg::LINE_ANALOG_BASE + i] = analog_cond[i];
    end
  end

  // per-peripheral flag and enable state
  always_comb begin
    flag_d   = flag_q;
    enable_d = enable_q;
    for (int u = 0; u < NL; u++) begin
      if (unit_wr.wr && (unit_wr.unit == u[irq_aggr_pkg::LINE_IDX_W-1:0])) begin
        flag_d[u]   = flag_d[u] & ~unit_wr.flag_clr;
        enable_d[u] = enable_d[u] | unit_wr.en_set;
        enable_d[u] = enable_d[u] & ~unit_wr.en_clr;
      end
      // condition sets flag; applied last so a new event beats the clear
      flag_d[u] = flag_d[u] | cond[u];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flag_q   <= {NL{irq_aggr_pkg::FLAG_RESET}};
      enable_q <= {NL{irq_aggr_pkg::ENABLE_RESET}};
    end else begin
      flag_q   <= flag_d;
      enable_q <= enable_d;
    end
  end

  // merged request per peripheral
  always_comb begin
    for (int u = 0; u < NL; u++) begin
      unit_req[u] = |(flag_q[u] & enable_q[u]);
    end
  end

  assign nmi_req = ext_nmi_cond;

  assign req_wide = {{(CW-NL){1'b0}}, unit_req};

  // controller pending, enable and priority state
  always_comb begin
    pending_d     = (pending_q & ~vctl_wr.pend_clr) | vctl_wr.pend_set | req_wide;
    line_enable_d = (line_enable_q | vctl_wr.ena_set) & ~vctl_wr.ena_clr;
    priority_d    = priority_q;
    if (vctl_wr.prio_wr) begin
      priority_d[vctl_wr.prio_idx] = vctl_wr.prio_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pending_q     <= irq_aggr_pkg::PEND_RESET;
      line_enable_q <= irq_aggr_pkg::LINE_EN_RESET;
      priority_q    <= {irq_aggr_pkg::PRIO_REGS{irq_aggr_pkg::PRIO_RESET}};
    end else begin
      pending_q     <= pending_d;
      line_enable_q <= line_enable_d;
      priority_q    <= priority_d;
    end
  end

  // lowest priority value wins, ties go to the lower line number
  assign prio_flat = priority_q;

  always_comb begin
    candidate      = pending_q & line_enable_q;
    active_valid_d = 1'b0;
    active_line_d  = '0;
    best_prio      = '1;
    for (int l = 0; l < NL; l++) begin
      if (candidate[l] &&
          (!active_valid_d || (prio_flat[l*PW +: PW] < best_prio))) begin
        active_valid_d = 1'b1;
        active_line_d  = l[irq_aggr_pkg::LINE_IDX_W-1:0];
        best_prio      = prio_flat[l*PW +: PW];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      active_valid_q <= 1'b0;
      active_line_q  <= '0;
    end else begin
      active_valid_q <= active_valid_d;
      active_line_q  <= active_line_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_flag_sets;
    cond[irq_aggr_pkg::LINE_TIMER_BASE][0] |=> flag_q[irq_aggr_pkg::LINE_TIMER_BASE][0];
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("flag did not set after condition");

  property p_en_set;
    // the strobe is gone by the next edge, so the unit index is taken from the past
    unit_wr.wr && (unit_wr.unit < 5'(irq_aggr_pkg::NUM_LINES)) &&
      unit_wr.en_set[0] && !unit_wr.en_clr[0] |=> enable_q[$past(unit_wr.unit)][0];
  endproperty
  a_en_set: assert property (p_en_set)
    else $error("enable set write ignored");

  property p_en_clr;
    unit_wr.wr && (unit_wr.unit < 5'(irq_aggr_pkg::NUM_LINES)) && unit_wr.en_clr[1]
      |=> !enable_q[$past(unit_wr.unit)][1];
  endproperty
  a_en_clr: assert property (p_en_clr)
    else $error("enable clear write ignored");

  property p_req_gated;
    (flag_d[irq_aggr_pkg::LINE_ADC] & enable_d[irq_aggr_pkg::LINE_ADC]) == 8'h00
      |=> !unit_req[irq_aggr_pkg::LINE_ADC];
  endproperty
  a_req_gated: assert property (p_req_gated)
    else $error("request without enabled flag");

  property p_req_or;
    flag_q[irq_aggr_pkg::LINE_WATCHDOG][7] && enable_q[irq_aggr_pkg::LINE_WATCHDOG][7]
      |-> unit_req[irq_aggr_pkg::LINE_WATCHDOG];
  endproperty
  a_req_or: assert property (p_req_or)
    else $error("enabled flag did not raise line");

  property p_pend;
    unit_req[irq_aggr_pkg::LINE_TOUCH_CTRL] |=> pending_q[irq_aggr_pkg::LINE_TOUCH_CTRL];
  endproperty
  a_pend: assert property (p_pend)
    else $error("request did not set pending");

  property p_active;
    (pending_q & line_enable_q) == 32'h0000_0000 |=> !active_valid_q;
  endproperty
  a_active: assert property (p_active)
    else $error("disabled or idle line activated");

  property p_prio;
    vctl_wr.prio_wr |=> priority_q[$past(vctl_wr.prio_idx)] == $past(vctl_wr.prio_data);
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority write lost");

  property p_flag_hold;
    flag_q[irq_aggr_pkg::LINE_RT_COUNTER][2] && !unit_wr.wr |=>
      flag_q[irq_aggr_pkg::LINE_RT_COUNTER][2];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without clear");

endmodule // peripheral_irq_aggregation

// ===== sim/core_model.sv
module core_model (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       active_valid_q,
  input  wire logic [4:0] active_line_q,
  input  wire logic       nmi_req,
  output logic      [4:0] taken_line,
  output logic      [7:0] nmi_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic nmi_d;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      taken_line <= 5'h00;
      nmi_cnt    <= 8'h00;
      nmi_d      <= 1'b0;
    end else begin
      nmi_d <= nmi_req;
      if (active_valid_q) begin
        taken_line <= active_line_q;
      end
      // counts edges, a held level is one entry
      if (nmi_req && !nmi_d) begin
        nmi_cnt <= nmi_cnt + 8'h01;
      end
    end
  end
endmodule // core_model

// ===== sim/peripheral_irq_aggregation_bench.sv
module peripheral_irq_aggregation_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      core_clk = 1'b0;
  logic                      rst_b = 1'b0;
  logic [6:0][7:0]           sys_cond = '0;
  logic [5:0][7:0]           serial_cond = '0;
  logic [7:0][7:0]           timer_cond = '0;
  logic [3:0][7:0]           analog_cond = '0;
  logic                      ext_nmi_cond = 1'b0;
  irq_aggr_pkg::unit_write_t unit_wr = '0;
  irq_aggr_pkg::vctl_write_t vctl_wr = '0;
  logic [24:0][7:0]          flag_q;
  logic [24:0][7:0]          enable_q;
  logic [24:0]               unit_req;
  logic [31:0]               pending_q;
  logic [31:0]               line_enable_q;
  logic [7:0][31:0]          priority_q;
  logic                      nmi_req;
  logic                      active_valid_q;
  logic [4:0]                active_line_q;
  logic [4:0]                taken_line;
  logic [7:0]                nmi_cnt;
  logic [7:0]                m;
  logic [7:0]                bit1;
  int                        n_fail = 0;
  int                        n_tests = 0;

  always #12.5 core_clk = ~core_clk;

  peripheral_irq_aggregation u_dut (.core_clk, .rst_b, .sys_cond, .serial_cond, .timer_cond,
    .analog_cond, .ext_nmi_cond, .unit_wr, .vctl_wr, .flag_q, .enable_q, .unit_req,
    .pending_q, .line_enable_q, .priority_q, .nmi_req, .active_valid_q, .active_line_q);
  core_model u_core (.core_clk, .rst_b, .active_valid_q, .active_line_q, .nmi_req,
    .taken_line, .nmi_cnt);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one request line per peripheral, at its fixed line number
  function automatic logic [31:0] line_bit(input int l);
    return 32'h1 << l;
  endfunction

  // source groups sit on fixed line ranges
  task automatic cnd(input int l, input logic [7:0] v);
    if (l < 7) sys_cond[l] <= v;
    else if (l < 13) serial_cond[l-7] <= v;
    else if (l < 21) timer_cond[l-13] <= v;
    else analog_cond[l-21] <= v;
  endtask

  task automatic uwr(input int l, input logic [7:0] fc, input logic [7:0] es,
                     input logic [7:0] ec);
    @(posedge core_clk);
    unit_wr <= {1'b1, 5'(l), fc, es, ec};
    @(posedge core_clk);
    unit_wr <= '0;
    #1;
  endtask

  task automatic nw(input irq_aggr_pkg::vctl_write_t w);
    @(posedge core_clk);
    vctl_wr <= w;
    @(posedge core_clk);
    vctl_wr <= '0;
    #1;
  endtask

  initial begin
    repeat (4000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hf1c2));
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int l = 0; l < 25; l++) begin
      bit1 = 8'h01 << ($urandom % 8);
      m = 8'($urandom) | bit1;
      uwr(l, 8'h00, m, 8'h00);
      chk(32'(enable_q[l]), 32'(m));
      @(posedge core_clk);
      cnd(l, bit1);
      @(posedge core_clk);
      cnd(l, 8'h00);
      #1;
      chk(32'(flag_q[l]), 32'(bit1));
      chk(32'(unit_req), line_bit(l));
      @(posedge core_clk);
      #1;
      chk(32'(pending_q[l]), 32'h1);
      uwr(l, 8'h00, 8'h00, bit1);
      chk(32'(enable_q[l]), 32'(m & ~bit1));
      chk(32'(unit_req), 32'h0);
      chk(32'(flag_q[l]), 32'(bit1));
      uwr(l, bit1, 8'h00, 8'h00);
      chk(32'(flag_q[l]), 32'h0);
    end
    chk(pending_q, 32'h01ff_ffff);
    chk(32'(active_valid_q), 32'h0);
    // line 13 gets a worse priority, so line 20 must win
    nw('{32'h0, 32'h0, 32'h0010_2000, 32'h0, 1'b1, 3'h3, 32'h0000_4000});
    @(posedge core_clk);
    #1;
    chk(priority_q[3], 32'h0000_4000);
    chk(line_enable_q, line_bit(13) | line_bit(20));
    chk(32'(active_line_q), 32'h14);
    nw('{32'h0, 32'h0, 32'h0, 32'h0010_0000, 1'b0, 3'h0, 32'h0});
    chk(32'(taken_line), 32'h14);
    @(posedge core_clk);
    #1;
    chk(32'(active_line_q), 32'h0d);
    nw('{32'h0, 32'hffff_ffff, 32'h0, 32'h0, 1'b0, 3'h0, 32'h0});
    chk(pending_q, 32'h0);
    nw('{32'h0100_0000, 32'h0, 32'h0, 32'h0, 1'b0, 3'h0, 32'h0});
    @(posedge core_clk);
    #1;
    chk(pending_q, 32'h0100_0000);
    chk(32'(active_valid_q), 32'h0);
    @(posedge core_clk);
    ext_nmi_cond <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(32'(nmi_req), 32'h1);
    chk(32'(nmi_cnt), 32'h1);
    chk(32'(active_valid_q), 32'h0);
    @(posedge core_clk);
    ext_nmi_cond <= 1'b0;
    end_sim();
  end
endmodule // peripheral_irq_aggregation_bench
